// ### logic/output_select_defines.svh
// Contract
// R1: Code 0: running or frequency above zero
// R2: Code 1: fault, excluding both communication faults
// R3: Code 2: frequency within width of reference
// R4: Code 3: frequency within width of level one
// R5: Code 4: hysteretic detection on pair one
// R6: Code 5: complement of code four detection
// R7: Codes 50-53 use pairs two, three
// R8: Code 6: active during automatic restart
// R9: Code 9: active during output block
// R10: Codes 12, 25: over and low torque
// R11: Code 13: current above level past delay
// R12: Code 18: run source setting equals three
// R13: Code 19: driven by programmable logic value
// R14: Code 20: frequency below minimum output frequency
// R15: Code 21: no fault and ready
// R16: Code 22: bus voltage below low level
// R17: Code 23: local run command mode
// R18: Code 24: local reference mode
// R19: Code 26: frequency reference lost
// R20: Code 27: timer function result
// R21: Code 32: communication control active
// R22: Code 37: PID feedback loss
// R23: Each output has own code register
// R24: Reserved or unsupported codes keep output off
// R25: Current outputs release after fixed 100 ms
`ifndef OUTPUT_SELECT_DEFINES_SVH
`define OUTPUT_SELECT_DEFINES_SVH

// Register byte offsets
`define OFS_CODE0        12'h000
`define OFS_CODE1        12'h004
`define OFS_CODE2        12'h008
`define OFS_LEVEL1       12'h010
`define OFS_LEVEL2       12'h014
`define OFS_LEVEL3       12'h018
`define OFS_CUR_LEVEL    12'h01c
`define OFS_CUR_DELAY    12'h020
`define OFS_SOURCES      12'h024
`define OFS_STATUS       12'h028
`define OFS_LOWCUR_LEVEL 12'h02c
`define OFS_LOWCUR_DELAY 12'h030

// Function codes
`define FC_RUN        6'h00
`define FC_FAULT      6'h01
`define FC_AGREE      6'h02
`define FC_SET_AGREE  6'h03
`define FC_DET1       6'h04
`define FC_DET2       6'h05
`define FC_RESTART    6'h06
`define FC_BLOCK      6'h09
`define FC_OVER_TRQ   6'h0c
`define FC_CUR_AGREE  6'h0d
`define FC_PLC_STAT   6'h12
`define FC_PLC_CTRL   6'h13
`define FC_ZERO_SPD   6'h14
`define FC_READY      6'h15
`define FC_UNDERVOLT  6'h16
`define FC_LOCAL_RUN  6'h17
`define FC_LOCAL_REF  6'h18
`define FC_LOW_TRQ    6'h19
`define FC_REF_LOSS   6'h1a
`define FC_TIMER      6'h1b
`define FC_COMM       6'h20
`define FC_PID_LOSS   6'h25
`define FC_DET3       6'h32
`define FC_DET4       6'h33
`define FC_DET5       6'h34
`define FC_DET6       6'h35
`define FC_LOW_CUR    6'h39

// Source setting values
`define SRC_LOCAL     2'h0
`define SRC_PLC       2'h3

// Timing
`define CLK_HZ        20000000
`define RELEASE_MS    100
`define DELAY_UNIT_MS 100

`endif

// ### logic/output_select_pkg.sv
package output_select_pkg;
    typedef logic [5:0]  func_code_t;
    typedef logic [15:0] freq_t;
    typedef logic [15:0] cur_t;
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_WAIT    = 2'b01,
        ST_ON      = 2'b11,
        ST_RELEASE = 2'b10
    } detect_state_t;
endpackage

// ### logic/status_output_selector.sv
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "output_select_defines.svh"

module status_output_selector #(
    parameter int NUM_OUT     = 3,
    parameter int RELEASE_CYC = `CLK_HZ / 1000 * `RELEASE_MS,
    parameter int UNIT_CYC    = `CLK_HZ / 1000 * `DELAY_UNIT_MS
) (
    // Clock and reset
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    // AHB-Lite slave
    input  wire logic                         hsel,
    input  wire logic [11:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic      [31:0]                  hrdata,
    output logic                              hreadyout,
    output logic                              hresp,
    // Drive conditions
    input  wire logic                         run_cmd,
    input  wire output_select_pkg::freq_t     out_freq,
    input  wire output_select_pkg::freq_t     freq_ref,
    input  wire output_select_pkg::freq_t     min_freq,
    input  wire output_select_pkg::cur_t      out_cur,
    input  wire logic                         fault,
    input  wire logic                         comm_fault_a,
    input  wire logic                         comm_fault_b,
    input  wire logic                         restart_active,
    input  wire logic                         output_blocked,
    input  wire logic                         over_torque,
    input  wire logic                         low_torque,
    input  wire logic                         plc_value,
    input  wire logic                         drive_ready,
    input  wire logic                         bus_low,
    input  wire logic                         local_select,
    input  wire logic                         ref_lost,
    input  wire logic                         timer_out,
    input  wire logic                         comm_control,
    input  wire logic                         pid_fbk_loss,
    // Relay drives
    output logic      [NUM_OUT-1:0]           relay_on
);
    import output_select_pkg::*;

    typedef struct packed {
        logic [NUM_OUT-1:0][5:0]  code;
        logic [2:0][15:0]         level;
        logic [2:0][15:0]         width;
        logic [15:0]              agree_width;
        logic [15:0]              cur_level;
        logic [15:0]              cur_delay;
        logic [15:0]              low_level;
        logic [15:0]              low_delay;
        logic [1:0]               run_src;
        logic [1:0]               ref_src;
        logic [2:0]               hyst;
        logic [1:0]               cur_st;
        logic [31:0]              cur_cnt;
        logic [1:0]               low_st;
        logic [31:0]              low_cnt;
        logic                     dph_wr;
        logic                     dph_rd;
        logic [11:0]              dph_addr;
        logic [31:0]              rdata;
        logic [NUM_OUT-1:0]       relay;
    } state_t;

    state_t s_q;
    state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic in_band(input logic [15:0] f,
                                     input logic [15:0] c,
                                     input logic [15:0] w);
        logic [16:0] hi;
        hi = {1'b0, c} + {1'b0, w};
        // Widened sums so levels near full scale never wrap
        return ({1'b0, f} <= hi) && ({1'b0, f} + {1'b0, w} >= {1'b0, c});
    endfunction

    function automatic logic above(input logic [15:0] f,
                                   input logic [15:0] c,
                                   input logic [15:0] w);
        return {1'b0, f} >= ({1'b0, c} + {1'b0, w});
    endfunction

    // Gray-coded detect step; delay counted in 0.1 s units
    function automatic logic [33:0] detect_step(input logic [1:0] st,
                                                input logic [31:0] cnt,
                                                input logic cond,
                                                input logic [15:0] dly);
        logic [1:0]  ns;
        logic [31:0] nc;
        logic [31:0] lim;
        ns  = st;
        nc  = cnt;
        lim = 32'(dly) * 32'(UNIT_CYC);
        case (detect_state_t'(st))
            ST_IDLE: begin
                nc = '0;
                if (cond) ns = ST_WAIT;
            end
            ST_WAIT: begin
                if (!cond) begin
                    ns = ST_IDLE;
                end else if (cnt >= lim) begin
                    ns = ST_ON;
                    nc = '0;
                end else begin
                    nc = cnt + 32'h1;
                end
            end
            ST_ON: begin
                nc = '0;
                if (!cond) ns = ST_RELEASE;
            end
            ST_RELEASE: begin
                if (cond) begin
                    ns = ST_ON;
                    nc = '0;
                end else if (cnt >= 32'(RELEASE_CYC - 1)) begin
                    ns = ST_IDLE;
                    nc = '0;
                end else begin
                    nc = cnt + 32'h1;
                end
            end
            default: begin
                ns = ST_IDLE;
                nc = '0;
            end
        endcase
        return {ns, nc};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state

    logic        addr_ok;
    logic [31:0] rd_val;
    logic [NUM_OUT-1:0] sel;

    always_comb begin
        logic [2:0] up;
        logic [2:0] dn;
        logic       cur_out;
        logic       low_out;
        s_d = s_q;
        // Hysteretic detectors: set at or above level+width, clear below level
        for (int k = 0; k < 3; k++) begin
            up[k] = above(out_freq, s_q.level[k], s_q.width[k]);
            dn[k] = out_freq < s_q.level[k];
            if (up[k]) s_d.hyst[k] = 1'b1; // see R5
            else if (dn[k]) s_d.hyst[k] = 1'b0; // see R5
        end
        {s_d.cur_st, s_d.cur_cnt} = detect_step(s_q.cur_st, s_q.cur_cnt,
            out_cur > s_q.cur_level, s_q.cur_delay); // see R11 see R25
        {s_d.low_st, s_d.low_cnt} = detect_step(s_q.low_st, s_q.low_cnt,
            (s_q.low_level != 16'h0) && (out_cur <= s_q.low_level),
            s_q.low_delay); // see R25
        cur_out = s_q.cur_st[1];
        low_out = s_q.low_st[1];

        for (int i = 0; i < NUM_OUT; i++) begin
            case (s_q.code[i]) // see R23
                `FC_RUN:       sel[i] = run_cmd || (out_freq != 16'h0); // see R1
                `FC_FAULT:     sel[i] = fault && !comm_fault_a
                                      && !comm_fault_b; // see R2
                `FC_AGREE:     sel[i] = in_band(out_freq, freq_ref,
                                        s_q.agree_width); // see R3
                `FC_SET_AGREE: sel[i] = in_band(out_freq, s_q.level[0],
                                        s_q.width[0]); // see R4
                `FC_DET1:      sel[i] = s_q.hyst[0]; // see R5
                `FC_DET2:      sel[i] = !s_q.hyst[0]; // see R6
                `FC_DET3:      sel[i] = s_q.hyst[1]; // see R7
                `FC_DET4:      sel[i] = !s_q.hyst[1]; // see R7
                `FC_DET5:      sel[i] = s_q.hyst[2]; // see R7
                `FC_DET6:      sel[i] = !s_q.hyst[2]; // see R7
                `FC_RESTART:   sel[i] = restart_active; // see R8
                `FC_BLOCK:     sel[i] = output_blocked; // see R9
                `FC_OVER_TRQ:  sel[i] = over_torque; // see R10
                `FC_LOW_TRQ:   sel[i] = low_torque; // see R10
                `FC_CUR_AGREE: sel[i] = cur_out; // see R11
                `FC_LOW_CUR:   sel[i] = low_out; // see R25
                `FC_PLC_STAT:  sel[i] = s_q.run_src == `SRC_PLC; // see R12
                `FC_PLC_CTRL:  sel[i] = plc_value; // see R13
                `FC_ZERO_SPD:  sel[i] = out_freq < min_freq; // see R14
                `FC_READY:     sel[i] = drive_ready && !fault; // see R15
                `FC_UNDERVOLT: sel[i] = bus_low; // see R16
                `FC_LOCAL_RUN: sel[i] = (s_q.run_src == `SRC_LOCAL)
                                      || local_select; // see R17
                `FC_LOCAL_REF: sel[i] = (s_q.ref_src == `SRC_LOCAL)
                                      || local_select; // see R18
                `FC_REF_LOSS:  sel[i] = ref_lost; // see R19
                `FC_TIMER:     sel[i] = timer_out; // see R20
                `FC_COMM:      sel[i] = comm_control; // see R21
                `FC_PID_LOSS:  sel[i] = pid_fbk_loss; // see R22
                default:       sel[i] = 1'b0; // see R24
            endcase
        end
        s_d.relay = sel;

        // Bus: address phase captured, write/read in data phase
        rd_val = 32'h0;
        addr_ok = 1'b1;
        case (s_q.dph_addr)
            `OFS_CODE0:    rd_val = {26'h0, s_q.code[0]};
            `OFS_CODE1:    rd_val = {26'h0, s_q.code[1]};
            `OFS_CODE2:    rd_val = {26'h0, s_q.code[2]};
            `OFS_LEVEL1:   rd_val = {s_q.width[0], s_q.level[0]};
            `OFS_LEVEL2:   rd_val = {s_q.width[1], s_q.level[1]};
            `OFS_LEVEL3:   rd_val = {s_q.width[2], s_q.level[2]};
            `OFS_CUR_LEVEL: rd_val = {s_q.agree_width, s_q.cur_level};
            `OFS_CUR_DELAY: rd_val = {16'h0, s_q.cur_delay};
            `OFS_SOURCES:  rd_val = {28'h0, s_q.ref_src, s_q.run_src};
            `OFS_STATUS:   rd_val = {22'h0, s_q.low_st, s_q.cur_st,
                                     s_q.hyst, s_q.relay[2:0]};
            `OFS_LOWCUR_LEVEL: rd_val = {16'h0, s_q.low_level};
            `OFS_LOWCUR_DELAY: rd_val = {16'h0, s_q.low_delay};
            default:       addr_ok = 1'b0;
        endcase
        if (s_q.dph_wr && addr_ok) begin
            case (s_q.dph_addr)
                `OFS_CODE0:  s_d.code[0] = hwdata[5:0];
                `OFS_CODE1:  s_d.code[1] = hwdata[5:0];
                `OFS_CODE2:  s_d.code[2] = hwdata[5:0];
                `OFS_LEVEL1: {s_d.width[0], s_d.level[0]} = hwdata;
                `OFS_LEVEL2: {s_d.width[1], s_d.level[1]} = hwdata;
                `OFS_LEVEL3: {s_d.width[2], s_d.level[2]} = hwdata;
                `OFS_CUR_LEVEL: {s_d.agree_width, s_d.cur_level} = hwdata;
                `OFS_CUR_DELAY: s_d.cur_delay = hwdata[15:0];
                `OFS_SOURCES: {s_d.ref_src, s_d.run_src} = hwdata[3:0];
                `OFS_LOWCUR_LEVEL: s_d.low_level = hwdata[15:0];
                `OFS_LOWCUR_DELAY: s_d.low_delay = hwdata[15:0];
                default: ;
            endcase
        end
        s_d.rdata = 32'h0;
        s_d.dph_wr = 1'b0;
        s_d.dph_rd = 1'b0;
        if (hsel && hready && htrans[1]) begin
            s_d.dph_addr = {haddr[11:2], 2'b00};
            s_d.dph_wr = hwrite;
            s_d.dph_rd = !hwrite;
        end
        if (s_q.dph_rd) s_d.rdata = rd_val;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.code <= {NUM_OUT{6'h3f}};
        end else begin
            s_q <= s_d;
        end
    end

    // Read data is registered: answers one cycle after data phase starts
    logic rd_wait_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) rd_wait_q <= 1'b0;
        else rd_wait_q <= s_q.dph_rd && !rd_wait_q;
    end

    assign hreadyout = !(s_q.dph_rd && !rd_wait_q);
    assign hresp     = 1'b0;
    assign hrdata    = s_q.rdata;
    assign relay_on  = s_q.relay;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_fault_comm_mask: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.code[0] == `FC_FAULT && (comm_fault_a || comm_fault_b))
        |=> !relay_on[0]) // see R2
        else $error("fault output set by communication fault");
    a_run_output: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.code[0] == `FC_RUN && $stable(s_q.code[0]) && run_cmd)
        |=> relay_on[0]) // see R1
        else $error("running output missing");
    a_hyst_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.hyst[0] && out_freq >= s_q.level[0]) |=> s_q.hyst[0]) // see R5
        else $error("detector released above level");
    a_reserved_off: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.code[0] == 6'h07 && $stable(s_q.code[0])) |=> !relay_on[0]) // see R24
        else $error("reserved code drove output");
    a_release_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.code[2] == `FC_CUR_AGREE && $stable(s_q.code[2])
         && detect_state_t'(s_q.cur_st) == ST_RELEASE)
        |=> relay_on[2]) // see R25
        else $error("current output released early");
    a_ready_fault: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.code[1] == `FC_READY && fault) |=> !relay_on[1]) // see R15
        else $error("ready with fault");
    a_zero_speed: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.code[2] == `FC_ZERO_SPD && $stable(s_q.code[2])
         && out_freq >= min_freq) |=> !relay_on[2]) // see R14
        else $error("zero speed above minimum");
    a_plc_status: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.code[1] == `FC_PLC_STAT && $stable(s_q.code[1])
         && s_q.run_src == `SRC_PLC && $stable(s_q.run_src))
        |=> relay_on[1]) // see R12
        else $error("plc status output missing");

endmodule // status_output_selector

// ### dv/relay_contacts.sv
`timescale 1ns/1ns
module relay_contacts #(
    parameter int N = 3
) (
    // Clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // Relay coils
    input  wire logic [N-1:0]       relay_on,
    // Length of the last closure, in clocks
    output logic      [N-1:0][15:0] last_len
);
    logic [N-1:0][15:0] run_q;

    ////////////////////////////////////////////////////////////////////////
    // Contacts only report how long each closure lasted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_q    <= '0;
            last_len <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (relay_on[i]) begin
                    run_q[i] <= run_q[i] + 16'h0001;
                end else if (run_q[i] != 16'h0000) begin
                    last_len[i] <= run_q[i];
                    run_q[i]    <= 16'h0000;
                end
            end
        end
    end
endmodule // relay_contacts

// ### dv/tb_status_output_selector.sv
`timescale 1ns/1ns
`include "output_select_defines.svh"
module tb_status_output_selector;
    import output_select_pkg::*;
    logic              hclk, hresetn, hsel, hwrite, hready;
    logic              hreadyout, hresp;
    logic [11:0]       haddr;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    logic [31:0]       hwdata, hrdata, rdata;
    logic              run_cmd, fault, comm_fault_a, comm_fault_b;
    logic              drive_ready, local_select;
    freq_t             out_freq, freq_ref, min_freq;
    cur_t              out_cur;
    logic [9:0]        flags;
    logic              restart_active, output_blocked, over_torque;
    logic              low_torque, plc_value, ref_lost, timer_out;
    logic              comm_control, pid_fbk_loss, bus_low;
    logic [2:0]        relay_on;
    logic [2:0][15:0]  last_len;
    int                fail_count, compares;
    logic [5:0]        fcs[10] = '{`FC_RESTART, `FC_BLOCK, `FC_OVER_TRQ,
        `FC_LOW_TRQ, `FC_PLC_CTRL, `FC_REF_LOSS, `FC_TIMER, `FC_COMM,
        `FC_PID_LOSS, `FC_UNDERVOLT};
    logic [5:0]        rsv[6] = '{6'h07, 6'h0a, 6'h0f, 6'h1c, 6'h1f, 6'h3f};
    logic [5:0]        on_fc[3] = '{`FC_DET1, `FC_DET3, `FC_DET5};
    logic [5:0]        off_fc[3] = '{`FC_DET2, `FC_DET4, `FC_DET6};
    int                ofs[5] = '{-10, 60, 20, -10, 20};
    logic              hex[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

    assign hready = hreadyout;
    assign {restart_active, output_blocked, over_torque, low_torque,
            plc_value, ref_lost, timer_out, comm_control, pid_fbk_loss,
            bus_low} = flags;

    status_output_selector #(.NUM_OUT(3), .RELEASE_CYC(20), .UNIT_CYC(10))
    i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .run_cmd(run_cmd), .out_freq(out_freq),
        .freq_ref(freq_ref), .min_freq(min_freq), .out_cur(out_cur),
        .fault(fault), .comm_fault_a(comm_fault_a),
        .comm_fault_b(comm_fault_b), .restart_active(restart_active),
        .output_blocked(output_blocked), .over_torque(over_torque),
        .low_torque(low_torque), .plc_value(plc_value),
        .drive_ready(drive_ready), .bus_low(bus_low),
        .local_select(local_select), .ref_lost(ref_lost),
        .timer_out(timer_out), .comm_control(comm_control),
        .pid_fbk_loss(pid_fbk_loss), .relay_on(relay_on));

    relay_contacts #(.N(3)) i_contacts (.hclk(hclk), .hresetn(hresetn),
        .relay_on(relay_on), .last_len(last_len));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Sample at the falling edge so the rising edge never races
    task automatic bus_wait();
        logic r;
        do begin
            @(negedge hclk);
            r = hready;
            rdata = hrdata;
            @(posedge hclk);
        end while (r !== 1'b1);
    endtask

    task automatic ahb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        bus_wait();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        bus_wait();
    endtask

    task automatic relay(input int n, input int i, input logic e);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
        chk("relay_on", 32'(relay_on[i]), 32'(e));
        @(posedge hclk);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    initial begin
        #(50 * 20000);
        fail_count++;
        $display("watchdog expired");
        results();
    end

    initial begin
        {hresetn, hsel, hwrite, run_cmd, fault, comm_fault_a} = '0;
        {comm_fault_b, drive_ready, local_select, flags} = '0;
        {haddr, htrans, hwdata, out_freq, freq_ref, min_freq} = '0;
        out_cur = '0;
        hsize = 3'h2;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(0, `OFS_CODE1, 0);
        chk("code_reset", rdata, 32'h0000003f);
        chk("hresp", 32'(hresp), 32'h00000000);
        ahb(1, 12'h100, 32'h00000001);
        ahb(0, 12'h100, 0);
        chk("unmapped", rdata, 32'h00000000);
        ahb(1, `OFS_CODE2, 32'h0000000d);
        ahb(0, `OFS_CODE2, 0);
        chk("code_rw", rdata, 32'h0000000d);
        $display("test registers done");
        // Reserved codes stay off with every condition true
        flags <= '1;
        {run_cmd, fault, drive_ready, local_select} <= 4'hf;
        out_freq <= 16'h0100;
        min_freq <= 16'h0200;
        for (int k = 0; k < 6; k++) begin
            ahb(1, `OFS_CODE0, 32'(rsv[k]));
            relay(4, 0, 1'b0);
        end
        flags <= '0;
        {run_cmd, fault, drive_ready, local_select} <= 4'h2;
        out_freq <= 16'h0000;
        $display("test reserved done");
        for (int k = 0; k < 10; k++) begin
            ahb(1, 12'(4 * (k % 3)), 32'(fcs[k]));
            flags <= ~(10'h200 >> k);
            relay(4, k % 3, 1'b0);
            flags <= 10'h200 >> k;
            relay(4, k % 3, 1'b1);
        end
        flags <= '0;
        $display("test flags done");
        ahb(1, `OFS_CODE0, 32'(`FC_RUN));
        ahb(1, `OFS_CODE1, 32'(`FC_FAULT));
        ahb(1, `OFS_CODE2, 32'(`FC_READY));
        fault <= 1'b0;
        relay(4, 0, 1'b0);
        relay(0, 1, 1'b0);
        relay(0, 2, 1'b1);
        run_cmd <= 1'b1;
        relay(4, 0, 1'b1);
        run_cmd <= 1'b0;
        out_freq <= 16'h0005;
        relay(4, 0, 1'b1);
        fault <= 1'b1;
        relay(4, 1, 1'b1);
        relay(0, 2, 1'b0);
        {fault, comm_fault_a, comm_fault_b} <= 3'b111;
        relay(4, 1, 1'b0);
        {comm_fault_a, comm_fault_b} <= 2'b00;
        ahb(1, `OFS_CODE2, 32'(`FC_ZERO_SPD));
        min_freq <= 16'd100;
        out_freq <= 16'd99;
        relay(4, 2, 1'b1);
        out_freq <= 16'd100;
        relay(4, 2, 1'b0);
        $display("test status done");
        ahb(1, `OFS_CODE0, 32'(`FC_PLC_STAT));
        ahb(1, `OFS_CODE1, 32'(`FC_LOCAL_RUN));
        ahb(1, `OFS_CODE2, 32'(`FC_LOCAL_REF));
        for (int s = 0; s < 4; s++) begin
            ahb(1, `OFS_SOURCES, 32'((s << 2) | s));
            relay(4, 0, 1'(s == 3));
            if (s < 3) begin
                relay(0, 1, 1'(s == 0));
                relay(0, 2, 1'(s == 0));
            end
        end
        ahb(1, `OFS_SOURCES, 32'h00000005);
        local_select <= 1'b1;
        relay(4, 1, 1'b1);
        relay(0, 2, 1'b1);
        local_select <= 1'b0;
        $display("test sources done");
        ahb(1, `OFS_CODE0, 32'(`FC_AGREE));
        ahb(1, `OFS_CODE1, 32'(`FC_SET_AGREE));
        ahb(1, `OFS_CUR_LEVEL, 32'h00320000);
        for (int p = 0; p < 3; p++)
            ahb(1, 12'(`OFS_LEVEL1 + 4 * p), {16'd50, 16'(500 + 1000 * p)});
        freq_ref <= 16'd1000;
        out_freq <= 16'd1020;
        relay(4, 0, 1'b1);
        relay(0, 1, 1'b0);
        out_freq <= 16'd510;
        relay(4, 0, 1'b0);
        relay(0, 1, 1'b1);
        out_freq <= 16'd700;
        relay(4, 1, 1'b0);
        $display("test agree done");
        for (int p = 0; p < 3; p++) begin
            ahb(1, `OFS_CODE0, 32'(on_fc[p]));
            ahb(1, `OFS_CODE1, 32'(off_fc[p]));
            for (int j = 0; j < 5; j++) begin
                out_freq <= 16'(500 + 1000 * p + ofs[j]);
                relay(4, 0, hex[j]);
                relay(0, 1, ~hex[j]);
            end
        end
        $display("test hysteresis done");
        ahb(1, `OFS_CODE2, 32'(`FC_CUR_AGREE));
        ahb(1, `OFS_CUR_LEVEL, 32'h00320064);
        ahb(1, `OFS_CUR_DELAY, 32'h00000001);
        out_cur <= 16'd200;
        relay(5, 2, 1'b0);
        relay(20, 2, 1'b1);
        out_cur <= 16'd0;
        relay(12, 2, 1'b1);
        relay(20, 2, 1'b0);
        chk("hold", 32'(last_len[2] >= 16'd20), 32'h1);
        $display("test current done");
        results();
    end
endmodule // tb_status_output_selector
